// file: design/dtp_pkg.sv
//------------------------------------------------------------
// Shared constants for the dual trigger and timestamp block
//------------------------------------------------------------
package dtp_pkg;

  //----------------------------------------------------------
  // Clock and time base
  //----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_TICK_NS    = 1000;
  localparam logic [5:0] CYC_PER_US = 6'(US_TICK_NS / CLK_PERIOD_NS);
  localparam logic [19:0] US_PER_SEC = 20'hF4240;
  localparam logic [25:0] US_PER_MS  = 26'h00003E8;

  //----------------------------------------------------------
  // Frequency range and reset values
  //----------------------------------------------------------
  localparam logic [7:0]  FREQ_MIN_HZ   = 8'h06;
  localparam logic [7:0]  FREQ_MAX_HZ   = 8'h32;
  localparam logic [7:0]  FREQ_RST_HZ   = 8'h0A;
  localparam logic [19:0] PERIOD_RST_US = 20'h186A0;
  localparam logic [15:0] WIDTH_RST_MS  = 16'h0001;
  localparam logic [19:0] OFFSET_RST_US = 20'h00000;

  //----------------------------------------------------------
  // Register indexes on the plain port
  //----------------------------------------------------------
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_FREQ   = 3'h1;
  localparam logic [2:0] REG_WIDTH0 = 3'h2;
  localparam logic [2:0] REG_WIDTH1 = 3'h3;
  localparam logic [2:0] REG_OFFSET = 3'h4;
  localparam logic [2:0] REG_PERIOD = 3'h5;
  localparam logic [2:0] REG_TIME   = 3'h6;
  localparam logic [2:0] REG_STAMP  = 3'h7;

  //----------------------------------------------------------
  // Control and period status field positions
  //----------------------------------------------------------
  localparam int CTRL_TRIG0_BIT = 0;
  localparam int CTRL_TRIG1_BIT = 1;
  localparam int CTRL_PPS_BIT   = 2;
  localparam int PERIOD_BUSY_BIT = 31;

endpackage : dtp_pkg

// file: design/dtp_trigger_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Primary and secondary triggers each have their own enable; disabled stays low.
// - Primary trigger frequency is programmable from 6 Hz to 50 Hz inclusive.
// - Primary pulse width is a programmable number of milliseconds.
// - Both trigger outputs are active high.
// - Secondary trigger can only pulse while the primary is enabled.
// - Secondary trigger always repeats at the primary frequency.
// - Secondary rising edge follows primary rising edge by a programmable offset.
// - Secondary trigger has its own programmable pulse width.
// - Secondary output is unusable while PPS sync is on; the pin is shared.
// - With PPS sync on, each sync pulse clears the time counter to zero.
// - Every captured frame pair is stamped with the time counter value.
// - Under PPS sync the stamp is time since the latest sync pulse.
module dtp_trigger_top
  import dtp_pkg::*;
#(
  parameter int TIME_W  = 32,
  parameter int PHASE_W = 20
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Register port
  input  wire logic [2:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdata,
  // Primary trigger pin
  output logic                   trig0Out,
  // Shared secondary trigger and PPS pin
  output logic                   trig1Out,
  output logic                   trig1Oe,
  input  wire logic              trig1In,
  // Frame capture event from the camera path
  input  wire logic              frameCapture
);

  //----------------------------------------------------------
  // Declarations
  //----------------------------------------------------------
  logic                ctrlTrig0En;
  logic                ctrlTrig1En;
  logic                ctrlPpsEn;
  logic [7:0]          freqHz;
  logic [15:0]         width0Ms;
  logic [15:0]         width1Ms;
  logic [PHASE_W-1:0]  offsetUs;
  logic [PHASE_W-1:0]  periodUs;
  logic [PHASE_W-1:0]  phase;
  logic [5:0]          usCnt;
  logic                usTick;
  logic [5:0]          phaseCnt;
  logic                phaseTick;
  logic                wrap;
  logic                divStart;
  logic                divBusy;
  logic                divDone;
  logic [19:0]         divQuot;
  logic                trig1Gate;
  logic                pinPrev;
  logic                ppsRise;
  logic [TIME_W-1:0]   timeUs;
  logic [TIME_W-1:0]   stamp;
  logic [PHASE_W:0]    periodLast;
  logic [PHASE_W-1:0]  w0Eff;
  logic [PHASE_W-1:0]  offEff;
  logic [PHASE_W-1:0]  w1Eff;
  logic [PHASE_W:0]    end1;
  logic                next_trig0;
  logic                next_trig1;
  logic [31:0]         next_rdata;

  //----------------------------------------------------------
  // Functions
  //----------------------------------------------------------

  // Milliseconds to microseconds
  function automatic logic [25:0] msToUs(input logic [15:0] ms);
    msToUs = 26'(26'(ms) * US_PER_MS);
  endfunction : msToUs

  // Limit a microsecond value to a ceiling
  function automatic logic [PHASE_W-1:0] clampUs(input logic [25:0]      val,
                                                 input logic [PHASE_W:0] lim);
    clampUs = (val > 26'(lim)) ? lim[PHASE_W-1:0] : val[PHASE_W-1:0];
  endfunction : clampUs

  // Hold a requested frequency inside the legal range
  function automatic logic [7:0] clampFreq(input logic [7:0] f);
    if (f < FREQ_MIN_HZ)
      clampFreq = FREQ_MIN_HZ;
    else if (f > FREQ_MAX_HZ)
      clampFreq = FREQ_MAX_HZ;
    else
      clampFreq = f;
  endfunction : clampFreq

  //----------------------------------------------------------
  // Control registers
  //----------------------------------------------------------

  // Enable bits
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrlTrig0En <= 1'b0;
      ctrlTrig1En <= 1'b0;
      ctrlPpsEn   <= 1'b0;
    end
    else if (regWrite && regAddr == REG_CTRL)
    begin
      ctrlTrig0En <= regWdata[CTRL_TRIG0_BIT];
      ctrlTrig1En <= regWdata[CTRL_TRIG1_BIT];
      ctrlPpsEn   <= regWdata[CTRL_PPS_BIT];
    end
  end

  // Frequency, widths and offset
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      freqHz   <= FREQ_RST_HZ;
      width0Ms <= WIDTH_RST_MS;
      width1Ms <= WIDTH_RST_MS;
      offsetUs <= PHASE_W'(OFFSET_RST_US);
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        REG_FREQ:   freqHz   <= clampFreq(regWdata[7:0]);
        REG_WIDTH0: width0Ms <= regWdata[15:0];
        REG_WIDTH1: width1Ms <= regWdata[15:0];
        REG_OFFSET: offsetUs <= regWdata[PHASE_W-1:0];
        default:    ;
      endcase
    end
  end

  //----------------------------------------------------------
  // Period from frequency
  //----------------------------------------------------------

  // Start division one cycle after a frequency write
  always_ff @(posedge mclk)
  begin
    if (reset)
      divStart <= 1'b0;
    else
      divStart <= regWrite && (regAddr == REG_FREQ);
  end

  dtp_udiv #(
    .NW (20),
    .DW (8)
  ) u_div (
    .mclk     (mclk),
    .reset    (reset),
    .start    (divStart),
    .dividend (US_PER_SEC),
    .divisor  (freqHz),
    .quotient (divQuot),
    .busy     (divBusy),
    .done     (divDone)
  );

  // Old period stays in use until the new one is ready
  always_ff @(posedge mclk)
  begin
    if (reset)
      periodUs <= PHASE_W'(PERIOD_RST_US);
    else if (divDone)
      periodUs <= PHASE_W'(divQuot);
  end

  //----------------------------------------------------------
  // Microsecond time base
  //----------------------------------------------------------

  // Prescaler, realigned by each sync pulse
  always_ff @(posedge mclk)
  begin
    if (reset || ppsRise || usTick)
      usCnt <= '0;
    else
      usCnt <= usCnt + 6'h01;
  end

  assign usTick = (usCnt == CYC_PER_US - 6'h01);

  // Period prescaler, restarted while idle so the first microsecond is whole
  always_ff @(posedge mclk)
  begin
    if (reset || !ctrlTrig0En || phaseTick)
      phaseCnt <= '0;
    else
      phaseCnt <= phaseCnt + 6'h01;
  end

  assign phaseTick = (phaseCnt == CYC_PER_US - 6'h01);
  assign wrap      = phaseTick && ({1'b0, phase} >= periodLast);

  //----------------------------------------------------------
  // Pulse limits
  //----------------------------------------------------------

  // Widths and offset clipped below one period
  always_comb
  begin
    periodLast = {1'b0, periodUs} - {{PHASE_W{1'b0}}, 1'b1};
    w0Eff      = clampUs(msToUs(width0Ms), periodLast);
    offEff     = clampUs(26'(offsetUs), periodLast);
    w1Eff      = clampUs(msToUs(width1Ms), periodLast - {1'b0, offEff});
    end1       = {1'b0, offEff} + {1'b0, w1Eff};
  end

  //----------------------------------------------------------
  // Trigger generation
  //----------------------------------------------------------

  // Shared period phase counter
  always_ff @(posedge mclk)
  begin
    if (reset || !ctrlTrig0En)
      phase <= '0;
    else if (wrap)
      phase <= '0;
    else if (phaseTick)
      phase <= phase + PHASE_W'(1);
  end

  // Secondary armed only at a period start, so its edge keeps the offset
  always_ff @(posedge mclk)
  begin
    if (reset || !ctrlTrig0En || !ctrlTrig1En || ctrlPpsEn)
      trig1Gate <= 1'b0;
    else if (wrap)
      trig1Gate <= 1'b1;
  end

  // Next levels of both trigger pins
  always_comb
  begin
    next_trig0 = ctrlTrig0En && (phase < w0Eff);
    next_trig1 = trig1Gate && ctrlTrig0En && ctrlTrig1En && !ctrlPpsEn
                 && (phase >= offEff) && ({1'b0, phase} < end1);
  end

  // Registered, active high pin drive
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      trig0Out <= 1'b0;
      trig1Out <= 1'b0;
      trig1Oe  <= 1'b0;
    end
    else
    begin
      trig0Out <= next_trig0;
      trig1Out <= next_trig1;
      trig1Oe  <= !ctrlPpsEn;
    end
  end

  //----------------------------------------------------------
  // PPS and timestamp
  //----------------------------------------------------------

  // Pin level history for edge detection
  always_ff @(posedge mclk)
  begin
    if (reset)
      pinPrev <= 1'b0;
    else
      pinPrev <= trig1In;
  end

  assign ppsRise = ctrlPpsEn && trig1In && !pinPrev;

  // Microsecond counter, cleared by each sync pulse
  always_ff @(posedge mclk)
  begin
    if (reset || ppsRise)
      timeUs <= '0;
    else if (usTick)
      timeUs <= timeUs + TIME_W'(1);
  end

  // Frame pair timestamp
  always_ff @(posedge mclk)
  begin
    if (reset)
      stamp <= '0;
    else if (frameCapture)
      stamp <= timeUs;
  end

  //----------------------------------------------------------
  // Register read port
  //----------------------------------------------------------

  // Read multiplexer
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (regAddr)
      REG_CTRL:
      begin
        next_rdata[CTRL_TRIG0_BIT] = ctrlTrig0En;
        next_rdata[CTRL_TRIG1_BIT] = ctrlTrig1En;
        next_rdata[CTRL_PPS_BIT]   = ctrlPpsEn;
      end
      REG_FREQ:   next_rdata[7:0]  = freqHz;
      REG_WIDTH0: next_rdata[15:0] = width0Ms;
      REG_WIDTH1: next_rdata[15:0] = width1Ms;
      REG_OFFSET: next_rdata[PHASE_W-1:0] = offsetUs;
      REG_PERIOD:
      begin
        next_rdata[PHASE_W-1:0]     = periodUs;
        next_rdata[PERIOD_BUSY_BIT] = divBusy;
      end
      REG_TIME:   next_rdata = 32'(timeUs);
      REG_STAMP:  next_rdata = 32'(stamp);
    endcase
  end

  // Data stand in the cycle after the read strobe only
  always_ff @(posedge mclk)
  begin
    if (reset || !regRead)
      regRdata <= 32'h00000000;
    else
      regRdata <= next_rdata;
  end

  //----------------------------------------------------------
  // Assertions
  //----------------------------------------------------------

  sequence s_ppsEdge;
    ctrlPpsEn && trig1In && !pinPrev;
  endsequence

  sequence s_capture;
    frameCapture && !reset;
  endsequence

  property p_trig0Off;
    @(posedge mclk) disable iff (reset)
    !ctrlTrig0En |=> !trig0Out;
  endproperty
  a_trig0Off: assert property (p_trig0Off)
    else $error("primary trigger high while disabled");

  property p_trig1NeedsPrimary;
    @(posedge mclk) disable iff (reset)
    (!ctrlTrig0En || !ctrlTrig1En) |=> !trig1Out;
  endproperty
  a_trig1NeedsPrimary: assert property (p_trig1NeedsPrimary)
    else $error("secondary trigger high without both enables");

  property p_ppsReleasesPin;
    @(posedge mclk) disable iff (reset)
    ctrlPpsEn |=> (!trig1Oe && !trig1Out);
  endproperty
  a_ppsReleasesPin: assert property (p_ppsReleasesPin)
    else $error("shared pin driven while PPS sync is on");

  property p_pinDriven;
    @(posedge mclk) disable iff (reset)
    (!reset && !ctrlPpsEn) |=> trig1Oe;
  endproperty
  a_pinDriven: assert property (p_pinDriven)
    else $error("secondary pin not driven while PPS sync is off");

  property p_ppsClear;
    @(posedge mclk) disable iff (reset)
    s_ppsEdge |=> (timeUs == '0) ##1 (timeUs == '0);
  endproperty
  a_ppsClear: assert property (p_ppsClear)
    else $error("time counter not cleared by sync pulse");

  property p_stamp;
    @(posedge mclk) disable iff (reset)
    s_capture |=> (stamp == $past(timeUs));
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("frame stamp does not match time counter");

  property p_freqRange;
    @(posedge mclk) disable iff (reset)
    1'b1 |-> (freqHz >= FREQ_MIN_HZ) && (freqHz <= FREQ_MAX_HZ);
  endproperty
  a_freqRange: assert property (p_freqRange)
    else $error("frequency outside legal range");

  property p_widthLimit;
    @(posedge mclk) disable iff (reset)
    1'b1 |-> (w0Eff < periodUs) && (end1 < {1'b0, periodUs});
  endproperty
  a_widthLimit: assert property (p_widthLimit)
    else $error("pulse reaches into the next period");

  property p_offsetEdge;
    @(posedge mclk) disable iff (reset)
    $rose(trig1Out) |-> ($past(phase) == $past(offEff));
  endproperty
  a_offsetEdge: assert property (p_offsetEdge)
    else $error("secondary edge not at programmed offset");

  property p_primaryStart;
    @(posedge mclk) disable iff (reset)
    $rose(trig0Out) |-> ($past(phase) == '0);
  endproperty
  a_primaryStart: assert property (p_primaryStart)
    else $error("primary edge not at period start");

endmodule : dtp_trigger_top

// file: design/dtp_udiv.sv
`timescale 1ns/10ps
//------------------------------------------------------------
// Iterative restoring divider, one quotient bit per cycle
//------------------------------------------------------------
module dtp_udiv
  import dtp_pkg::*;
#(
  parameter int NW = 20,
  parameter int DW = 8
)
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // Request
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  // Result
  output logic      [NW-1:0] quotient,
  output logic               busy,
  output logic               done
);

  logic [DW-1:0] rem;
  logic [5:0]    cnt;
  logic [DW:0]   trial;
  logic          fits;

  // Shifted partial remainder and its trial compare
  always_comb
  begin
    trial = {rem, quotient[NW-1]};
    fits  = (trial >= {1'b0, divisor});
  end

  // One step per cycle until all quotient bits are formed
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rem      <= '0;
      quotient <= '0;
      cnt      <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end
    else if (start)
    begin
      rem      <= '0;
      quotient <= dividend;
      cnt      <= 6'(NW);
      busy     <= 1'b1;
      done     <= 1'b0;
    end
    else if (busy)
    begin
      rem      <= fits ? DW'(trial - {1'b0, divisor}) : trial[DW-1:0];
      quotient <= {quotient[NW-2:0], fits};
      cnt      <= cnt - 6'h01;
      busy     <= (cnt != 6'h01);
      done     <= (cnt == 6'h01);
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule : dtp_udiv

// file: dv/dtp_partner.sv
`timescale 1ns/10ps
//------------------------------------------------------------
// Camera pair and PPS source on the far side of the pins
//------------------------------------------------------------
module dtp_partner
(
  // Clock
  input  wire logic mclk,
  // Trigger pins from the device
  input  wire logic trig0Out,
  input  wire logic trig1Out,
  input  wire logic trig1Oe,
  // PPS source control from the bench
  input  wire logic ppsDrive,
  input  wire logic ppsLevel,
  // Shared pin level and capture event
  output logic      trig1In,
  output logic      frameCapture,
  output int        exposures0,
  output int        exposures1
);
  logic prev0;
  logic prev1;
  logic pinLast;

  // Power-up state of the cameras
  initial
  begin
    prev0        = 1'b0;
    prev1        = 1'b0;
    pinLast      = 1'b0;
    frameCapture = 1'b0;
    exposures0   = 0;
    exposures1   = 0;
  end

  // Pin level: device when driving, else PPS source, else a changing value
  assign trig1In = trig1Oe ? trig1Out : (ppsDrive ? ppsLevel : ~pinLast);

  // Exposure starts on each rising trigger edge; fast frame rate misses none
  always @(posedge mclk)
  begin
    prev0        <= trig0Out;
    prev1        <= trig1Out & trig1Oe;
    pinLast      <= trig1In;
    frameCapture <= trig0Out & ~prev0;
    if (trig0Out && !prev0)
      exposures0 <= exposures0 + 1;
    if (trig1Out && trig1Oe && !prev1)
      exposures1 <= exposures1 + 1;
  end

endmodule : dtp_partner

// file: dv/dtp_trigger_top_tb_top.sv
`timescale 1ns/10ps
//------------------------------------------------------------
// Self-checking bench for the trigger and timestamp block
//------------------------------------------------------------
module dtp_trigger_top_tb_top
  import dtp_pkg::*;
;

  logic        mclk;
  logic        reset;
  logic [2:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        trig0Out;
  logic        trig1Out;
  logic        trig1Oe;
  logic        trig1In;
  logic        frameCapture;
  logic        ppsDrive;
  logic        ppsLevel;
  int          exposures0;
  int          exposures1;
  int          fails;
  int          n_tests;

  //----------------------------------------------------------
  // Device, partner and clock
  //----------------------------------------------------------
  dtp_trigger_top #(.TIME_W(32), .PHASE_W(20)) dtp_trigger_top_i (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .trig0Out(trig0Out), .trig1Out(trig1Out),
    .trig1Oe(trig1Oe), .trig1In(trig1In), .frameCapture(frameCapture));

  dtp_partner dtp_partner_i (
    .mclk(mclk), .trig0Out(trig0Out), .trig1Out(trig1Out), .trig1Oe(trig1Oe),
    .ppsDrive(ppsDrive), .ppsLevel(ppsLevel), .trig1In(trig1In),
    .frameCapture(frameCapture), .exposures0(exposures0), .exposures1(exposures1));

  // Free-running 40 MHz clock
  always #12.5 mclk = ~mclk;

  //----------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------
  task automatic conclude;
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask : rd

  task automatic rdChk(input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdChk

  //----------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------
  task automatic testResetValues;
    rdChk(REG_CTRL, 32'h0);
    rdChk(REG_TIME, 32'h0);
    rdChk(REG_FREQ, {24'h0, FREQ_RST_HZ});
    rdChk(REG_WIDTH0, {16'h0, WIDTH_RST_MS});
    rdChk(REG_WIDTH1, {16'h0, WIDTH_RST_MS});
    rdChk(REG_OFFSET, {12'h0, OFFSET_RST_US});
    rdChk(REG_PERIOD, {12'h0, PERIOD_RST_US});
    rdChk(REG_STAMP, 32'h0);
  endtask : testResetValues

  task automatic testFreqRange;
    logic [31:0] d;
    wr(REG_FREQ, 32'h3);
    rdChk(REG_FREQ, {24'h0, FREQ_MIN_HZ});
    wr(REG_FREQ, 32'h3C);
    rdChk(REG_FREQ, {24'h0, FREQ_MAX_HZ});
    rd(REG_PERIOD, d);
    chk({31'h0, d[PERIOD_BUSY_BIT]}, 32'h1);
    repeat (30) @(posedge mclk);
    rdChk(REG_PERIOD, 32'h4E20);
    wr(REG_FREQ, 32'h6);
    repeat (30) @(posedge mclk);
    rdChk(REG_PERIOD, 32'h28B0A);
  endtask : testFreqRange

  task automatic testRegAccess;
    wr(REG_WIDTH1, 32'hABCD1234);
    rdChk(REG_WIDTH1, 32'h1234);
    wr(REG_OFFSET, 32'hFFF12345);
    rdChk(REG_OFFSET, 32'h12345);
    wr(REG_PERIOD, 32'hFFFF);
    rdChk(REG_PERIOD, 32'h28B0A);
    wr(REG_WIDTH1, 32'h1);
    wr(REG_OFFSET, 32'h0);
  endtask : testRegAccess

  task automatic testPrimaryPulse;
    int n;
    int hi1;
    n   = 0;
    hi1 = 0;
    wr(REG_WIDTH0, 32'h1);
    wr(REG_CTRL, 32'h3);
    while (trig0Out !== 1'b1 && n < 6)
    begin
      @(negedge mclk);
      n++;
    end
    chk(n, 32'h2);
    n = 0;
    while (trig0Out === 1'b1 && n < 50000)
    begin
      if (trig1Out !== 1'b0)
        hi1++;
      @(negedge mclk);
      n++;
    end
    chk(n, 32'h9C40);
    chk(hi1, 32'h0);
    chk(exposures0, 32'h1);
    wr(REG_CTRL, 32'h0);
    repeat (2) @(negedge mclk);
    chk({31'h0, trig0Out}, 32'h0);
  endtask : testPrimaryPulse

  task automatic testSecondaryGating;
    int bad;
    bad = 0;
    wr(REG_CTRL, 32'h2);
    repeat (100)
    begin
      @(negedge mclk);
      if (trig0Out !== 1'b0 || trig1Out !== 1'b0 || trig1Oe !== 1'b1)
        bad++;
    end
    chk(bad, 32'h0);
    wr(REG_CTRL, 32'h7);
    repeat (3) @(negedge mclk);
    chk({30'h0, trig1Oe, trig1Out}, 32'h0);
    wr(REG_CTRL, 32'h0);
  endtask : testSecondaryGating

  task automatic testPpsStamp;
    wr(REG_CTRL, 32'h4);
    repeat (3) @(negedge mclk);
    chk({31'h0, trig1Oe}, 32'h0);
    @(posedge mclk);
    ppsLevel <= 1'b1;
    repeat (10) @(posedge mclk);
    ppsLevel <= 1'b0;
    repeat (205) @(posedge mclk);
    wr(REG_CTRL, 32'h5);
    repeat (10) @(posedge mclk);
    rdChk(REG_STAMP, 32'h5);
    @(posedge mclk);
    ppsLevel <= 1'b1;
    repeat (3) @(posedge mclk);
    rdChk(REG_TIME, 32'h0);
    ppsLevel <= 1'b0;
    wr(REG_CTRL, 32'h0);
  endtask : testPpsStamp

  //----------------------------------------------------------
  // Main sequence and watchdog
  //----------------------------------------------------------
  initial
  begin
    mclk     = 1'b0;
    reset    = 1'b1;
    regAddr  = 3'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    ppsDrive = 1'b1;
    ppsLevel = 1'b0;
    fails    = 0;
    n_tests  = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    testResetValues();
    testFreqRange();
    testRegAccess();
    testPrimaryPulse();
    testSecondaryGating();
    testPpsStamp();
    conclude();
  end

  // Cut a hang short well past the expected run length
  initial
  begin
    repeat (100000) @(posedge mclk);
    fails++;
    conclude();
  end

endmodule : dtp_trigger_top_tb_top
